// file: design/bwt_pkg.sv
// Constants, types and register map of the bridge waveform timer.
package bwt_pkg;
  localparam int CNT_W = 12;
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h1;
  localparam logic [3:0] OFS_CTRL3 = 4'h2;
  localparam logic [3:0] OFS_DLYCTL = 4'h3;
  localparam logic [3:0] OFS_DLYVAL = 4'h4;
  localparam logic [3:0] OFS_EVCTL = 4'h5;
  localparam logic [3:0] OFS_CMP0 = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'ha;
  localparam logic [3:0] OFS_CAP_A = 4'hb;
  localparam logic [3:0] OFS_CAP_B = 4'hc;
  localparam logic [3:0] OFS_COUNT = 4'hd;
  localparam int F_EN = 0;
  localparam int F_SRC = 1;
  localparam int F_CPRE = 3;
  localparam int F_SPRE = 5;
  localparam int F_SEL_C = 0;
  localparam int F_SEL_D = 1;
  localparam int F_CAP = 2;
  localparam int F_BLANK = 8;
  localparam int F_ASYNC = 10;
  localparam int F_CAPEV = 12;
  localparam int F_RDY = 3;
  localparam logic [1:0] SHAPE_ONE = 2'h0;
  localparam logic [1:0] SHAPE_TWO = 2'h1;
  localparam logic [1:0] SHAPE_FOUR = 2'h2;
  localparam logic [1:0] SHAPE_DUAL = 2'h3;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [11:0] CMP_RST = 12'h000;
  typedef enum logic [3:0] {ST_DTA = 4'h1, ST_OTA = 4'h2, ST_DTB = 4'h4, ST_OTB = 4'h8} bwt_state_t;
  typedef struct packed {logic wave_out_a; logic wave_out_b; logic wave_out_c; logic wave_out_d;} bwt_wave_t;
  typedef struct packed {logic cmp_a; logic cmp_b; logic ovf; logic delayed;} bwt_evt_t;
  typedef struct packed {logic kill_all; logic kill_own; logic restart; logic jump; logic latch; logic hold;} bwt_act_t;
endpackage

// file: design/bwt_core.sv
// Bridge waveform timer: register port, prescalers, counting core, inputs and outputs.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bwt_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic [2:0] count_src_tick,
  input wire logic [1:0] event_in,
  output var bwt_pkg::bwt_wave_t wave,
  output var bwt_pkg::bwt_evt_t evt
);
  logic [6:0] ctrl1_reg;
  logic [1:0] ctrl2_reg;
  logic [1:0] ctrl3_reg;
  logic [1:0] dly_ctrl_reg;
  logic [7:0] dly_val_reg;
  logic [15:0] evctl_reg;
  logic [11:0] cmp_sh_reg [4];
  logic [11:0] cmp_act_reg [4];
  logic [11:0] cap_reg [2];
  logic [2:0] flag_reg;
  logic [11:0] cnt_reg;
  logic [11:0] end_val;
  bwt_pkg::bwt_state_t st_reg;
  bwt_pkg::bwt_state_t st_d_reg;
  bwt_pkg::bwt_state_t st_next;
  logic down_reg;
  logic en_meta_reg;
  logic en_sync_reg;
  logic latch_reg;
  logic a_reg;
  logic b_reg;
  logic c_reg;
  logic d_reg;
  logic [3:0] src_vec;
  logic src_tick;
  logic [2:0] pre_in;
  logic [2:0] pre_out;
  logic [1:0] pre_sel [3];
  logic cnt_tick;
  logic dly_tick;
  logic [1:0] ev_ok;
  logic [1:0] ev_prev_reg;
  logic [1:0] ev_rise;
  logic [1:0] blank_start;
  logic [1:0] blank_done;
  bwt_pkg::bwt_act_t act [2];
  logic hold_any;
  logic jump_any;
  logic run_tick;
  logic match;
  logic cycle_end;
  logic a_raw;
  logic b_raw;
  logic kill_a;
  logic kill_b;
  logic async_kill;
  logic [1:0] shape;
  logic wr_static;

  assign shape = ctrl2_reg;
  assign wr_static = wr_en && !ctrl1_reg[bwt_pkg::F_EN];

  // Shape, counter prescale and event setup are static: they are locked while the timer runs.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl1_reg <= bwt_pkg::REG_RST[6:0];
      ctrl2_reg <= bwt_pkg::REG_RST[1:0];
      ctrl3_reg <= bwt_pkg::REG_RST[1:0];
      evctl_reg <= bwt_pkg::REG_RST;
      dly_ctrl_reg <= bwt_pkg::REG_RST[1:0];
      dly_val_reg <= bwt_pkg::REG_RST[7:0];
    end
    else if (ce)
    begin
      if (wr_en && addr == bwt_pkg::OFS_CTRL1)
      begin
        ctrl1_reg[bwt_pkg::F_EN] <= wr_data[bwt_pkg::F_EN];
        if (!ctrl1_reg[bwt_pkg::F_EN])
          ctrl1_reg[6:1] <= wr_data[6:1];
      end
      if (wr_static && addr == bwt_pkg::OFS_CTRL2)
        ctrl2_reg <= wr_data[1:0];
      if (wr_static && addr == bwt_pkg::OFS_CTRL3)
        ctrl3_reg <= wr_data[1:0];
      if (wr_static && addr == bwt_pkg::OFS_EVCTL)
        evctl_reg <= wr_data;
      // Delay prescale lives apart from the counter prescale.
      if (wr_en && addr == bwt_pkg::OFS_DLYCTL)
        dly_ctrl_reg <= wr_data[1:0];
      if (wr_en && addr == bwt_pkg::OFS_DLYVAL)
        dly_val_reg <= wr_data[7:0];
    end
  end

  // Compare values are double buffered so a running cycle never sees a torn pair.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        cmp_sh_reg[k] <= bwt_pkg::CMP_RST;
        cmp_act_reg[k] <= bwt_pkg::CMP_RST;
      end
    end
    else if (ce)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (wr_en && addr == bwt_pkg::OFS_CMP0 + 4'(k))
          cmp_sh_reg[k] <= wr_data[11:0];
        if (!en_sync_reg || cycle_end)
          cmp_act_reg[k] <= cmp_sh_reg[k];
      end
    end
  end

  // Enable passes two flops before the core acts on it.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      en_meta_reg <= ctrl1_reg[bwt_pkg::F_EN];
      en_sync_reg <= en_meta_reg;
    end
  end

  // Four sources: the system clock and three external count ticks.
  assign src_vec = {count_src_tick, 1'b1};
  assign src_tick = src_vec[ctrl1_reg[bwt_pkg::F_SRC +: 2]];
  assign pre_in = {src_tick, pre_out[0], src_tick};
  assign pre_sel[0] = ctrl1_reg[bwt_pkg::F_SPRE +: 2];
  assign pre_sel[1] = ctrl1_reg[bwt_pkg::F_CPRE +: 2];
  assign pre_sel[2] = dly_ctrl_reg;

  // Count prescaler runs on the sync prescaler output, so factors multiply.
  for (genvar i = 0; i < 3; i++)
  begin : g_pre
    logic [2:0] pc_reg;
    logic [2:0] mask;
    assign mask = 3'((4'h1 << pre_sel[i]) - 4'h1);
    assign pre_out[i] = pre_in[i] && ((pc_reg & mask) == mask);
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        pc_reg <= 3'h0;
      else if (ce)
      begin
        if (!en_sync_reg)
          pc_reg <= 3'h0;
        else if (pre_in[i])
          pc_reg <= pc_reg + 3'h1;
      end
    end
  end
  assign cnt_tick = pre_out[1] && en_sync_reg;
  // Delay timing uses its own prescaler.
  assign dly_tick = pre_out[2] && en_sync_reg;

  function automatic bwt_pkg::bwt_act_t mode_act(input logic [3:0] m);
    bwt_pkg::bwt_act_t r;
    r = '0;
    case (m)
      4'h1: r.jump = 1'b1;
      4'h2: r.kill_all = 1'b1;
      4'h3: r.restart = 1'b1;
      4'h4: {r.kill_all, r.restart} = 2'h3;
      4'h5: r.kill_own = 1'b1;
      4'h6: r.latch = 1'b1;
      4'h7: r.hold = 1'b1;
      4'h8: {r.hold, r.kill_own} = 2'h3;
      4'h9: {r.jump, r.kill_own} = 2'h3;
      default: r = '0;
    endcase
    return r;
  endfunction

  assign blank_start[0] = st_reg == bwt_pkg::ST_OTA && st_d_reg != bwt_pkg::ST_OTA;
  assign blank_start[1] = st_reg == bwt_pkg::ST_OTB && st_d_reg != bwt_pkg::ST_OTB;

  for (genvar j = 0; j < 2; j++)
  begin : g_in
    logic [7:0] blank_reg;
    // Blanking window opens at the start of this channel's on time.
    assign ev_ok[j] = event_in[j] && (blank_reg == 8'h00 || !evctl_reg[bwt_pkg::F_BLANK + j]);
    assign ev_rise[j] = ev_ok[j] && !ev_prev_reg[j];
    assign blank_done[j] = blank_reg == 8'h01 && dly_tick;
    // Each channel decodes its own mode.
    assign act[j] = mode_act(evctl_reg[4 * j +: 4]);
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        blank_reg <= 8'h00;
        ev_prev_reg[j] <= 1'b0;
      end
      else if (ce)
      begin
        ev_prev_reg[j] <= ev_ok[j];
        if (!en_sync_reg)
          blank_reg <= 8'h00;
        else if (blank_start[j] && evctl_reg[bwt_pkg::F_BLANK + j])
          blank_reg <= dly_val_reg;
        else if (dly_tick && blank_reg != 8'h00)
          blank_reg <= blank_reg - 8'h01;
      end
    end
  end

  // Level actions follow the event; jumps fire on its rising edge.
  assign hold_any = (ev_ok[0] && act[0].hold) || (ev_ok[1] && act[1].hold);
  assign jump_any = (ev_rise[0] && (act[0].jump || act[0].restart))
    || (ev_rise[1] && (act[1].jump || act[1].restart));
  assign run_tick = cnt_tick && !hold_any && !jump_any;
  assign kill_a = (ev_ok[0] && (act[0].kill_all || act[0].kill_own))
    || (ev_ok[1] && act[1].kill_all) || latch_reg;
  assign kill_b = (ev_ok[1] && (act[1].kill_all || act[1].kill_own))
    || (ev_ok[0] && act[0].kill_all) || latch_reg;

  always_comb
  begin
    case (st_reg)
      bwt_pkg::ST_DTA: end_val = cmp_act_reg[0];
      bwt_pkg::ST_OTA: end_val = cmp_act_reg[1];
      bwt_pkg::ST_DTB: end_val = cmp_act_reg[2];
      bwt_pkg::ST_OTB: end_val = cmp_act_reg[3];
      default: end_val = cmp_act_reg[3];
    endcase
  end
  assign match = cnt_reg == end_val;
  // The four states rotate in a fixed order.
  assign st_next = bwt_pkg::bwt_state_t'({st_reg[2:0], st_reg[3]});
  assign cycle_end = run_tick && ((shape == bwt_pkg::SHAPE_ONE && cnt_reg == cmp_act_reg[3])
    || (shape == bwt_pkg::SHAPE_TWO && st_reg == bwt_pkg::ST_OTB && match)
    || (shape == bwt_pkg::SHAPE_FOUR && st_reg == bwt_pkg::ST_OTB && match)
    || (shape == bwt_pkg::SHAPE_DUAL && down_reg && cnt_reg == 12'h000));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 12'h000;
      st_reg <= bwt_pkg::ST_DTA;
      st_d_reg <= bwt_pkg::ST_DTA;
      down_reg <= 1'b0;
    end
    else if (ce)
    begin
      st_d_reg <= st_reg;
      // The core only moves on its own prescaled count enable.
      if (!en_sync_reg)
      begin
        cnt_reg <= 12'h000;
        st_reg <= bwt_pkg::ST_DTA;
        down_reg <= 1'b0;
      end
      else if (cnt_tick && jump_any)
      begin
        cnt_reg <= 12'h000;
        down_reg <= 1'b0;
        if (ev_rise[0] && act[0].jump)
          st_reg <= bwt_pkg::ST_DTB;
        else
          st_reg <= bwt_pkg::ST_DTA;
      end
      else if (run_tick)
      begin
        case (shape)
          bwt_pkg::SHAPE_ONE:
          begin
            // Only the clear value of unit B ends the ramp.
            if (cnt_reg == cmp_act_reg[3])
            begin
              cnt_reg <= 12'h000;
              st_reg <= bwt_pkg::ST_DTA;
            end
            else
            begin
              cnt_reg <= cnt_reg + 12'h001;
              if (match)
                st_reg <= st_next;
            end
          end
          bwt_pkg::SHAPE_TWO:
          begin
            // Ramps end on the clear values of A and B.
            if (match && (st_reg == bwt_pkg::ST_OTA || st_reg == bwt_pkg::ST_OTB))
              cnt_reg <= 12'h000;
            else
              cnt_reg <= cnt_reg + 12'h001;
            if (match)
              st_reg <= st_next;
          end
          bwt_pkg::SHAPE_FOUR:
          begin
            // Every state ends with a counter reset.
            if (match)
            begin
              cnt_reg <= 12'h000;
              st_reg <= st_next;
            end
            else
              cnt_reg <= cnt_reg + 12'h001;
          end
          default:
          begin
            // Turn at the top value, climb again at zero.
            if (!down_reg)
            begin
              if (cnt_reg >= cmp_act_reg[3])
              begin
                down_reg <= 1'b1;
                cnt_reg <= (cnt_reg == 12'h000) ? 12'h000 : cnt_reg - 12'h001;
                st_reg <= bwt_pkg::ST_DTB;
              end
              else
                cnt_reg <= cnt_reg + 12'h001;
            end
            else if (cnt_reg == 12'h000)
            begin
              down_reg <= 1'b0;
              cnt_reg <= 12'h001;
              st_reg <= bwt_pkg::ST_DTA;
            end
            else
              cnt_reg <= cnt_reg - 12'h001;
          end
        endcase
      end
    end
  end

  // On time follows its dead time; dual slope uses level compares.
  assign a_raw = (shape == bwt_pkg::SHAPE_DUAL) ? (cnt_reg < cmp_act_reg[0])
    : (st_reg == bwt_pkg::ST_OTA);
  assign b_raw = (shape == bwt_pkg::SHAPE_DUAL) ? (cnt_reg > cmp_act_reg[2])
    : (st_reg == bwt_pkg::ST_OTB);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      c_reg <= 1'b0;
      d_reg <= 1'b0;
      latch_reg <= 1'b0;
    end
    else if (ce)
    begin
      a_reg <= en_sync_reg && a_raw && !kill_a;
      b_reg <= en_sync_reg && b_raw && !kill_b;
      // C and D copy the selected unit output.
      c_reg <= ctrl3_reg[bwt_pkg::F_SEL_C] ? b_reg : a_reg;
      d_reg <= ctrl3_reg[bwt_pkg::F_SEL_D] ? b_reg : a_reg;
      if (!en_sync_reg)
        latch_reg <= 1'b0;
      else if ((ev_ok[0] && act[0].latch) || (ev_ok[1] && act[1].latch))
        latch_reg <= 1'b1;
    end
  end

  // Fault path bypasses the flops so the stage goes off at once.
  assign async_kill = |(event_in & evctl_reg[bwt_pkg::F_ASYNC +: 2]);
  assign wave = '{wave_out_a: a_reg && !async_kill, wave_out_b: b_reg && !async_kill,
    wave_out_c: c_reg && !async_kill, wave_out_d: d_reg && !async_kill};

  // Software strobe or input event copies the counter.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_reg[0] <= 12'h000;
      cap_reg[1] <= 12'h000;
    end
    else if (ce)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if ((wr_en && addr == bwt_pkg::OFS_CTRL3 && wr_data[bwt_pkg::F_CAP + k])
            || (ev_rise[k] && evctl_reg[bwt_pkg::F_CAPEV + k]))
          cap_reg[k] <= cnt_reg;
      end
    end
  end

  // Flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_reg <= 3'h0;
      evt <= '0;
    end
    else if (ce)
    begin
      // Overflow and compare events as pulses and sticky flags.
      evt.ovf <= cycle_end;
      evt.cmp_a <= cnt_tick && (cnt_reg == cmp_act_reg[0] || cnt_reg == cmp_act_reg[1]);
      evt.cmp_b <= cnt_tick && (cnt_reg == cmp_act_reg[2] || cnt_reg == cmp_act_reg[3]);
      evt.delayed <= |blank_done;
      flag_reg <= (flag_reg & ~((wr_en && addr == bwt_pkg::OFS_STATUS) ? wr_data[2:0] : 3'h0))
        | {evt.cmp_b, evt.cmp_a, evt.ovf};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rd_data <= bwt_pkg::REG_RST;
    else if (ce)
    begin
      rd_data <= bwt_pkg::REG_RST;
      if (rd_en)
      begin
        case (addr)
          bwt_pkg::OFS_CTRL1: rd_data <= {9'h000, ctrl1_reg};
          bwt_pkg::OFS_CTRL2: rd_data <= {14'h0000, ctrl2_reg};
          bwt_pkg::OFS_CTRL3: rd_data <= {14'h0000, ctrl3_reg};
          bwt_pkg::OFS_DLYCTL: rd_data <= {14'h0000, dly_ctrl_reg};
          bwt_pkg::OFS_DLYVAL: rd_data <= {8'h00, dly_val_reg};
          bwt_pkg::OFS_EVCTL: rd_data <= evctl_reg;
          bwt_pkg::OFS_CMP0: rd_data <= {4'h0, cmp_sh_reg[0]};
          bwt_pkg::OFS_CMP0 + 4'h1: rd_data <= {4'h0, cmp_sh_reg[1]};
          bwt_pkg::OFS_CMP0 + 4'h2: rd_data <= {4'h0, cmp_sh_reg[2]};
          bwt_pkg::OFS_CMP0 + 4'h3: rd_data <= {4'h0, cmp_sh_reg[3]};
          bwt_pkg::OFS_STATUS: rd_data <= {12'h000, en_sync_reg == ctrl1_reg[bwt_pkg::F_EN], flag_reg};
          bwt_pkg::OFS_CAP_A: rd_data <= {4'h0, cap_reg[0]};
          bwt_pkg::OFS_CAP_B: rd_data <= {4'h0, cap_reg[1]};
          bwt_pkg::OFS_COUNT: rd_data <= {4'h0, cnt_reg};
          default: rd_data <= bwt_pkg::REG_RST;
        endcase
      end
    end
  end

  a_enable_sync: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(ce) && $past(ce, 2)) |-> en_sync_reg == $past(ctrl1_reg[bwt_pkg::F_EN], 2))
    else $error("enable did not cross in two cycles");
  a_one_ramp_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && run_tick && shape == bwt_pkg::SHAPE_ONE && cnt_reg == cmp_act_reg[3])
    |=> cnt_reg == 12'h000 && st_reg == bwt_pkg::ST_DTA)
    else $error("one ramp did not wrap at top");
  a_two_ramp_mid: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && run_tick && shape == bwt_pkg::SHAPE_TWO && match && st_reg == bwt_pkg::ST_OTA)
    |=> cnt_reg == 12'h000 && st_reg == bwt_pkg::ST_DTB)
    else $error("two ramp missed mid reset");
  a_four_ramp_step: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && run_tick && shape == bwt_pkg::SHAPE_FOUR && match)
    |=> cnt_reg == 12'h000 && st_reg == $past(st_next))
    else $error("four ramp state did not reset");
  a_dual_turn: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && run_tick && shape == bwt_pkg::SHAPE_DUAL && !down_reg
      && cnt_reg >= cmp_act_reg[3] && cnt_reg != 12'h000)
    |=> down_reg && cnt_reg == $past(cnt_reg) - 12'h001)
    else $error("dual slope did not turn");
  a_ovf_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && cycle_end) ##1 ce |=> flag_reg[0])
    else $error("overflow flag not set");
  a_async_kill: assert property (@(posedge clk) disable iff (sys_rst)
    (event_in[0] && evctl_reg[bwt_pkg::F_ASYNC]) |-> !wave.wave_out_a && !wave.wave_out_d)
    else $error("fault did not force outputs off");
  a_static_lock: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(ctrl1_reg[bwt_pkg::F_EN]) && $past(ce)) |-> $stable(ctrl2_reg) && $stable(evctl_reg))
    else $error("static setup changed while running");
  a_capture_sw: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && wr_en && addr == bwt_pkg::OFS_CTRL3 && wr_data[bwt_pkg::F_CAP])
    |=> cap_reg[0] == $past(cnt_reg))
    else $error("software capture lost");
endmodule
`default_nettype wire

// file: testbench/bwt_stage_model.sv
// Behavioural power stage and event source facing the waveform timer.
`timescale 1ns/10ps
`default_nettype none
module bwt_stage_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire bwt_pkg::bwt_wave_t wave,
  input wire logic [1:0] fault_cmd,
  output logic [1:0] event_in,
  output logic [2:0] count_src_tick,
  output logic overlap
);
  logic [2:0] div_reg;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_reg <= 3'h0;
      event_in <= 2'h0;
    end
    else
    begin
      div_reg <= div_reg + 3'h1;
      event_in <= fault_cmd;
    end
  end
  // Sources one to three tick on every second, fourth and eighth clock.
  assign count_src_tick = {div_reg == 3'h7, div_reg[1:0] == 2'h3, div_reg[0]};
  // Both legs on at once would short the supply, so the stage reports it.
  assign overlap = wave.wave_out_a & wave.wave_out_b;
endmodule
`default_nettype wire

// file: testbench/async_bridge_waveform_timer_tb_top.sv
// Self-checking testbench of the bridge waveform timer.
`timescale 1ns/10ps
`default_nettype none
module async_bridge_waveform_timer_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [2:0] count_src_tick;
  logic [1:0] event_in;
  logic [1:0] fault_cmd = 2'h0;
  logic overlap;
  bwt_pkg::bwt_wave_t wave;
  bwt_pkg::bwt_evt_t evt;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] rv;
  logic prev_a;
  logic seen_a;
  logic [1:0] shp [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [15:0] c1 [6] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0029, 16'h0003};
  logic [15:0] per [6] = '{16'h000c, 16'h0012, 16'h001e, 16'h0016, 16'h0030, 16'h0018};

  always #12.5 clk = ~clk;

  bwt_core u_dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .count_src_tick(count_src_tick),
    .event_in(event_in), .wave(wave), .evt(evt));

  bwt_stage_model u_stage (.clk(clk), .sys_rst(sys_rst), .wave(wave), .fault_cmd(fault_cmd),
    .event_in(event_in), .count_src_tick(count_src_tick), .overlap(overlap));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Cycles from one overflow pulse to the next; zero when none arrives.
  task automatic period(output logic [15:0] p);
    int n;
    n = 0;
    p = 16'h0000;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (n < 400 && evt.ovf !== 1'b1);
    for (n = 1; n < 400; n++)
    begin
      @(posedge clk);
      #1;
      if (evt.ovf === 1'b1)
      begin
        p = 16'(n);
        break;
      end
    end
  endtask

  task automatic test_done;
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      chk_rd(4'(i), 16'h0000);
    chk_rd(4'he, 16'h0000);
    wr(4'hf, 16'h1234);
    chk_rd(4'hf, 16'h0000);
    for (int i = 0; i < 4; i++)
      wr(4'(6 + i), 16'(2 + 3 * i));
    for (int i = 0; i < 4; i++)
      chk_rd(4'(6 + i), 16'(2 + 3 * i));
    for (int i = 0; i < 6; i++)
    begin
      wr(bwt_pkg::OFS_CTRL1, 16'h0000);
      repeat (4) @(posedge clk);
      wr(bwt_pkg::OFS_CTRL2, {14'h0, shp[i]});
      wr(bwt_pkg::OFS_CTRL1, c1[i]);
      period(rv);
      period(rv);
      chk(rv, per[i]);
    end
    // Shape changes must be refused while the timer runs.
    wr(bwt_pkg::OFS_CTRL2, 16'h0003);
    chk_rd(bwt_pkg::OFS_CTRL2, 16'h0000);
    chk_rd(bwt_pkg::OFS_CTRL1, 16'h0003);
    wr(bwt_pkg::OFS_CTRL1, 16'h0000);
    repeat (4) @(posedge clk);
    wr(bwt_pkg::OFS_EVCTL, 16'h0402);
    wr(bwt_pkg::OFS_CTRL1, 16'h0001);
    seen_a = 1'b0;
    prev_a = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      fault_cmd <= (i >= 30 && i < 45) ? 2'h1 : 2'h0;
      #1;
      if (i >= 32 && i <= 45)
        chk({12'h0, wave}, 16'h0000);
      else if (i >= 2 && i < 30)
        chk({15'h0, wave.wave_out_c}, {15'h0, prev_a});
      chk({15'h0, overlap}, 16'h0000);
      seen_a = seen_a | wave.wave_out_a;
      prev_a = wave.wave_out_a;
    end
    chk({15'h0, seen_a}, 16'h0001);
    wr(bwt_pkg::OFS_CTRL1, 16'h0000);
    repeat (4) @(posedge clk);
    rd(bwt_pkg::OFS_STATUS, rv);
    chk(rv & 16'h000f, 16'h000f);
    wr(bwt_pkg::OFS_STATUS, 16'h0007);
    rd(bwt_pkg::OFS_STATUS, rv);
    chk(rv & 16'h0007, 16'h0000);
    // A held counter gives a nonzero value that a lost capture would miss.
    wr(bwt_pkg::OFS_EVCTL, 16'h0007);
    wr(bwt_pkg::OFS_CTRL1, 16'h0001);
    repeat (7) @(posedge clk);
    fault_cmd <= 2'h1;
    repeat (3) @(posedge clk);
    rd(bwt_pkg::OFS_COUNT, rv);
    chk(rv, 16'h0006);
    wr(bwt_pkg::OFS_CTRL3, 16'h0004);
    chk_rd(bwt_pkg::OFS_CAP_A, rv);
    test_done();
  end
endmodule
`default_nettype wire
